// *** inc/video_port_pkg.sv ***
// constants and types shared by the video port timing block
package video_port_pkg;

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LEAD = 8'h04;
    localparam logic [7:0] OFF_ROWDLY = 8'h08;
    localparam logic [7:0] OFF_FRMDLY = 8'h0c;
    localparam logic [7:0] OFF_FPC = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam logic [7:0] LEAD_RST = 8'h00;
    localparam logic [7:0] ROWDLY_RST = 8'h00;
    localparam logic [7:0] FRMDLY_RST = 8'h00;
    localparam logic [15:0] FPC_RST = 16'h01f8;

    // figures in pixel clocks (one link clock each)
    localparam logic [15:0] LINE_LO_LVL = 16'h0074;
    localparam logic [15:0] LINE_HI_LVL = 16'h0298;
    localparam logic [15:0] LINE_HI_PULSE = 16'h02fc;
    localparam logic [15:0] SYNC_PULSE = 16'h0010;
    localparam logic [15:0] FRAME_BASE = 16'h0074;
    localparam logic [15:0] LINE_TOTAL = 16'h030c;
    localparam logic [7:0] SLAVE_FIRST = 8'h7c;
    localparam logic [7:0] SYNC_LAT = 8'h03;
    localparam logic [7:0] SLAVE_LOAD = SLAVE_FIRST - SYNC_LAT;

    localparam int TRIG_ROW = 0;
    localparam int TRIG_FRAME = 1;
    localparam int TRIG_SNAP = 2;

    typedef enum logic [1:0] {
        MODE_LEVEL = 2'b00,
        MODE_PULSE = 2'b01,
        MODE_SLAVE = 2'b10,
        MODE_SNAP = 2'b11
    } mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_MASTER = 3'b001,
        ST_SLAVE = 3'b010,
        ST_SNAP_ARM = 3'b011,
        ST_SNAP_WAIT = 3'b100
    } link_state_t;

    typedef struct packed {
        logic en;
        mode_t mode;
        logic [7:0] lead;
        logic [7:0] rowdly;
        logic [7:0] fdly;
        logic [15:0] fpc;
    } cfg_t;

    typedef struct packed {
        link_state_t state;
        logic [15:0] frames;
        logic [15:0] shots;
    } stat_t;

    localparam cfg_t CFG_RST = '{1'b0, MODE_LEVEL, LEAD_RST, ROWDLY_RST, FRMDLY_RST, FPC_RST};

endpackage

// *** verilog/word_sync.sv ***
// handshake crossing that carries a word from one clock domain to another
`timescale 1ns/1ps
module word_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic src_clk,
    input wire logic src_rst_n,
    input wire logic [W-1:0] src_data,
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    output logic [W-1:0] dst_data,
    output logic dst_upd
);
    if (W < 1) begin : g_bad_width
        $error("word_sync: W must be at least 1");
    end

    logic [W-1:0] hold_r;
    logic req_r, ack_s1_r, ack_s2_r;
    logic req_s1_r, req_s2_r, ack_r;
    wire src_idle = (ack_s2_r == req_r);
    wire dst_take = (req_s2_r != ack_r);

    // hold_r only moves once the far side has acknowledged, so it is stable while sampled
    always_ff @(posedge src_clk or negedge src_rst_n) begin
        if (!src_rst_n) begin
            hold_r <= RST;
            req_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_r;
            ack_s2_r <= ack_s1_r;
            if (src_idle) begin
                hold_r <= src_data;
                req_r <= ~req_r;
            end
        end
    end

    always_ff @(posedge dst_clk or negedge dst_rst_n) begin
        if (!dst_rst_n) begin
            dst_data <= RST;
            dst_upd <= 1'b0;
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            dst_upd <= dst_take && (hold_r != dst_data);
            if (dst_take) begin
                dst_data <= hold_r;
                ack_r <= req_s2_r;
            end
        end
    end
endmodule

// *** verilog/video_port.sv ***
// video port timing generator with apb registers and a link clock domain
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module video_port
    import video_port_pkg::*;
#(
    parameter int PIX_W = 12,
    parameter int ROW_PIXELS = 648
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MCLK,
    input wire logic ROW_TRIG,
    input wire logic FRAME_TRIG,
    input wire logic SNAP_TRIG,
    output logic LINE_SYNC,
    output logic FRAME_SYNC,
    output logic PIX_VALID,
    output logic [PIX_W-1:0] PIX_DATA,
    output logic EXT_SHUTTER_SYNC
);
    if (PIX_W < 8 || PIX_W > 16 || ROW_PIXELS < 1 || ROW_PIXELS > 65535) begin : g_bad_param
        $error("video_port: PIX_W must be 8..16 and ROW_PIXELS 1..65535");
    end

    localparam logic [15:0] ROW_LEN = 16'(ROW_PIXELS);

    // ---------------- register side ----------------
    logic en_r;
    mode_t mode_r;
    logic [7:0] lead_r, rowdly_r, fdly_r;
    logic [15:0] fpc_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    stat_t stat_s;

    wire sel_ctrl = (PADDR == OFF_CTRL);
    wire sel_lead = (PADDR == OFF_LEAD);
    wire sel_rowdly = (PADDR == OFF_ROWDLY);
    wire sel_fdly = (PADDR == OFF_FRMDLY);
    wire sel_fpc = (PADDR == OFF_FPC);
    wire sel_stat = (PADDR == OFF_STATUS);
    wire hit = sel_ctrl | sel_lead | sel_rowdly | sel_fdly | sel_fpc | sel_stat;
    wire first_acc = PSEL & PENABLE & ~pready_r;
    wire wr_en = PSEL & PENABLE & pready_r & PWRITE;
    wire [31:0] rd_ctrl = {29'h0, mode_r, en_r};
    wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                         sel_lead ? {24'h0, lead_r} :
                         sel_rowdly ? {24'h0, rowdly_r} :
                         sel_fdly ? {24'h0, fdly_r} :
                         sel_fpc ? {16'h0, fpc_r} :
                         sel_stat ? {stat_s.shots, stat_s.frames} : 32'h0;
    wire cfg_t cfg_s = '{en_r, mode_r, lead_r, rowdly_r, fdly_r, fpc_r};

    // one wait state keeps the bus outputs registered
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= first_acc;
            pslverr_r <= first_acc & ~hit;
            if (first_acc) begin
                prdata_r <= (PWRITE || !hit) ? 32'h0 : rd_mux;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            en_r <= 1'b0;
            mode_r <= MODE_LEVEL;
            lead_r <= LEAD_RST;
            rowdly_r <= ROWDLY_RST;
            fdly_r <= FRMDLY_RST;
            fpc_r <= FPC_RST;
        end else if (wr_en) begin
            if (sel_ctrl) begin
                en_r <= PWDATA[CTRL_EN_BIT];
                mode_r <= mode_t'(PWDATA[CTRL_MODE_LSB +: 2]);
            end
            if (sel_lead) lead_r <= PWDATA[7:0];
            if (sel_rowdly) rowdly_r <= PWDATA[7:0];
            if (sel_fdly) fdly_r <= PWDATA[7:0];
            if (sel_fpc) fpc_r <= PWDATA[15:0];
        end
    end

    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PRDATA = prdata_r;

    // ---------------- crossings ----------------
    cfg_t cfg_l;
    logic cfg_upd;
    stat_t stat_l;

    word_sync #(.W($bits(cfg_t)), .RST(CFG_RST)) u_cfg_sync (
        .src_clk(CLK_SYS), .src_rst_n(RESETN), .src_data(cfg_s),
        .dst_clk(MCLK), .dst_rst_n(RESETN), .dst_data(cfg_l), .dst_upd(cfg_upd)
    );

    word_sync #(.W($bits(stat_t))) u_stat_sync (
        .src_clk(MCLK), .src_rst_n(RESETN), .src_data(stat_l),
        .dst_clk(CLK_SYS), .dst_rst_n(RESETN), .dst_data(stat_s), .dst_upd()
    );

    // ---------------- link side, all on MCLK ----------------
    logic [2:0] trig_s1_r, trig_s2_r, trig_d_r;
    link_state_t st_r, st_nxt;
    logic ls_r, ls_nxt, fs_r, fs_nxt, valid_r, valid_nxt, ext_r, ext_nxt;
    logic sl_wait_r, sl_wait_nxt;
    logic [7:0] sl_cnt_r, sl_cnt_nxt;
    logic [15:0] pos_r, pos_nxt, fpos_r, fpos_nxt, frames_r, frames_nxt, shots_r, shots_nxt;
    logic [31:0] snap_cnt_r, snap_cnt_nxt;
    logic [PIX_W-1:0] pix_r, pix_nxt;

    wire [2:0] trig_edge = trig_s2_r & ~trig_d_r;
    wire is_level = (cfg_l.mode == MODE_LEVEL);
    wire [15:0] lead16 = {8'h00, cfg_l.lead};
    // lead above 116+rowdly or fpc below 116+frame_delay wraps these lengths; software keeps them in range
    wire [15:0] line_lo = is_level ? LINE_LO_LVL + {8'h00, cfg_l.rowdly} - lead16 : SYNC_PULSE;
    wire [15:0] line_hi = is_level ? LINE_HI_LVL - lead16 : LINE_HI_PULSE;
    wire [15:0] frm_lo = is_level ? {8'h00, cfg_l.fdly} + FRAME_BASE : SYNC_PULSE;
    wire [15:0] frm_hi = is_level ? cfg_l.fpc - FRAME_BASE - {8'h00, cfg_l.fdly} : SYNC_PULSE;
    wire [15:0] pos_inc = pos_r + 16'h0001;
    wire [15:0] fpos_inc = fpos_r + 16'h0001;
    wire line_end = pos_inc >= (ls_r ? line_hi : line_lo);
    wire frm_end = fpos_inc >= (fs_r ? frm_hi : frm_lo);
    wire [31:0] snap_tgt = {16'h0, cfg_l.fpc} * {16'h0, LINE_TOTAL};
    wire link_state_t mode_st = !cfg_l.en ? ST_IDLE :
                                (cfg_l.mode == MODE_SLAVE) ? ST_SLAVE :
                                (cfg_l.mode == MODE_SNAP) ? ST_SNAP_ARM : ST_MASTER;
    wire mode_ok = (st_r == mode_st) || (mode_st == ST_SNAP_ARM && st_r == ST_SNAP_WAIT);

    always_comb begin
        st_nxt = st_r;
        ls_nxt = ls_r;
        fs_nxt = fs_r;
        pos_nxt = pos_r;
        fpos_nxt = fpos_r;
        sl_wait_nxt = sl_wait_r;
        sl_cnt_nxt = sl_cnt_r;
        snap_cnt_nxt = snap_cnt_r;
        frames_nxt = frames_r;
        shots_nxt = shots_r;
        ext_nxt = 1'b0;
        if (!mode_ok) begin
            st_nxt = mode_st;
            ls_nxt = 1'b0;
            fs_nxt = 1'b0;
            pos_nxt = 16'h0;
            fpos_nxt = 16'h0;
            sl_wait_nxt = 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                end
                ST_MASTER: begin
                    ls_nxt = line_end ? ~ls_r : ls_r;
                    pos_nxt = line_end ? 16'h0 : pos_inc;
                    fs_nxt = frm_end ? ~fs_r : fs_r;
                    fpos_nxt = frm_end ? 16'h0 : fpos_inc;
                    if (frm_end && !fs_r) frames_nxt = frames_r + 16'h0001;
                end
                ST_SLAVE: begin
                    fs_nxt = trig_s2_r[TRIG_FRAME];
                    if (trig_edge[TRIG_FRAME]) frames_nxt = frames_r + 16'h0001;
                    if (trig_edge[TRIG_ROW] && !ls_r && !sl_wait_r) begin
                        sl_wait_nxt = 1'b1;
                        sl_cnt_nxt = SLAVE_LOAD;
                    end else if (sl_wait_r) begin
                        if (sl_cnt_r == 8'h00) begin
                            sl_wait_nxt = 1'b0;
                            ls_nxt = 1'b1;
                            pos_nxt = 16'h0;
                        end else begin
                            sl_cnt_nxt = sl_cnt_r - 8'h01;
                        end
                    end else if (ls_r) begin
                        ls_nxt = pos_inc < ROW_LEN;
                        pos_nxt = pos_inc;
                    end
                end
                ST_SNAP_ARM: begin
                    if (trig_edge[TRIG_SNAP]) begin
                        st_nxt = ST_SNAP_WAIT;
                        snap_cnt_nxt = 32'h0;
                    end
                end
                ST_SNAP_WAIT: begin
                    if (snap_cnt_r >= snap_tgt) begin
                        ext_nxt = 1'b1;
                        st_nxt = ST_SNAP_ARM;
                        shots_nxt = shots_r + 16'h0001;
                    end else begin
                        snap_cnt_nxt = snap_cnt_r + 32'h1;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // data is registered from the next position so the first pixel lines up with the sync edge in slave mode and comes lead clocks after it in master modes
    wire master_valid = ls_nxt && (pos_nxt >= lead16);
    assign valid_nxt = (st_r == ST_SLAVE && mode_ok) ? ls_nxt : (st_r == ST_MASTER && mode_ok && master_valid);
    assign pix_nxt = !valid_nxt ? '0 :
                     (st_r == ST_SLAVE) ? pos_nxt[PIX_W-1:0] : PIX_W'(pos_nxt - lead16);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            trig_s1_r <= 3'h0;
            trig_s2_r <= 3'h0;
            trig_d_r <= 3'h0;
        end else begin
            trig_s1_r <= {SNAP_TRIG, FRAME_TRIG, ROW_TRIG};
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
        end
    end

    // every link output changes on the rising edge of MCLK only
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= ST_IDLE;
            {ls_r, fs_r, valid_r, ext_r, sl_wait_r} <= 5'h0;
            sl_cnt_r <= 8'h0;
            {pos_r, fpos_r, frames_r, shots_r} <= 64'h0;
            snap_cnt_r <= 32'h0;
            pix_r <= '0;
        end else begin
            st_r <= st_nxt;
            {ls_r, fs_r, valid_r, ext_r, sl_wait_r} <= {ls_nxt, fs_nxt, valid_nxt, ext_nxt, sl_wait_nxt};
            sl_cnt_r <= sl_cnt_nxt;
            {pos_r, fpos_r, frames_r, shots_r} <= {pos_nxt, fpos_nxt, frames_nxt, shots_nxt};
            snap_cnt_r <= snap_cnt_nxt;
            pix_r <= pix_nxt;
        end
    end

    assign stat_l = '{st_r, frames_r, shots_r};
    assign LINE_SYNC = ls_r;
    assign FRAME_SYNC = fs_r;
    assign PIX_VALID = valid_r;
    assign PIX_DATA = pix_r;
    assign EXT_SHUTTER_SYNC = ext_r;

    // ---------------- checks ----------------
    logic [15:0] seg_cnt_r, fseg_cnt_r;
    logic [1:0] chg_cnt_r, fchg_cnt_r;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            {seg_cnt_r, fseg_cnt_r} <= 32'h0;
            {chg_cnt_r, fchg_cnt_r} <= 4'h0;
        end else begin
            seg_cnt_r <= (ls_nxt != ls_r) ? 16'h1 : seg_cnt_r + 16'h1;
            fseg_cnt_r <= (fs_nxt != fs_r) ? 16'h1 : fseg_cnt_r + 16'h1;
            if (cfg_upd || !mode_ok) begin
                {chg_cnt_r, fchg_cnt_r} <= 4'h0;
            end else begin
                if (ls_nxt != ls_r && chg_cnt_r != 2'h3) chg_cnt_r <= chg_cnt_r + 2'h1;
                if (fs_nxt != fs_r && fchg_cnt_r != 2'h3) fchg_cnt_r <= fchg_cnt_r + 2'h1;
            end
        end
    end

    wire settled = (st_r == ST_MASTER) && (chg_cnt_r == 2'h3) && !cfg_upd;

    a_line_lo_len: assert property (@(posedge MCLK) disable iff (!RESETN)
        settled && $rose(ls_r) |-> $past(seg_cnt_r) == line_lo)
        else $error("line sync low time wrong");
    a_line_hi_len: assert property (@(posedge MCLK) disable iff (!RESETN)
        settled && $fell(ls_r) |-> $past(seg_cnt_r) == line_hi)
        else $error("line sync high time wrong");
    a_first_pixel_lead: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_r == ST_MASTER) && $rose(valid_r) |-> ls_r && seg_cnt_r == lead16 + 16'h1)
        else $error("first pixel not lead clocks after line sync");
    a_frame_lo_len: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_r == ST_MASTER) && fchg_cnt_r == 2'h3 && !cfg_upd && $rose(fs_r) |-> $past(fseg_cnt_r) == frm_lo)
        else $error("frame sync low time wrong");
    a_frame_hi_len: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_r == ST_MASTER) && fchg_cnt_r == 2'h3 && !cfg_upd && $fell(fs_r) |-> $past(fseg_cnt_r) == frm_hi)
        else $error("frame sync high time wrong");
    a_slave_first_pixel: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_r == ST_SLAVE) && mode_ok && !ls_r && !sl_wait_r && trig_edge[TRIG_ROW]
        |-> ##122 !valid_r ##1 valid_r)
        else $error("slave first pixel not 124 clocks after row trigger");
    a_snap_shutter_gap: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(ext_r) |-> $past(snap_cnt_r) >= snap_tgt)
        else $error("shutter sync earlier than one frame period");
    a_slave_row_framing: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_r == ST_SLAVE) && valid_r && $past(valid_r) |-> pix_r == $past(pix_r) + 1'b1)
        else $error("slave pixel data not counting within a row");

    c_master_line: cover property (@(posedge MCLK) disable iff (!RESETN) settled && $rose(ls_r));
    c_slave_row: cover property (@(posedge MCLK) disable iff (!RESETN) (st_r == ST_SLAVE) && $rose(valid_r));
    c_snap_shot: cover property (@(posedge MCLK) disable iff (!RESETN) $rose(ext_r));
endmodule

// *** tb/trig_model.sv ***
// trigger source standing in for the frame grabber at the far side of the link
`timescale 1ns/1ps
module trig_model
    import video_port_pkg::*;
(
    input wire logic mclk,
    output logic row_trig,
    output logic frame_trig,
    output logic snap_trig
);
    initial begin
        row_trig = 1'b0;
        frame_trig = 1'b0;
        snap_trig = 1'b0;
    end
    // two edges high: the shortest pulse that the pin synchroniser is sure to see
    task automatic pulse(input int which);
        @(posedge mclk);
        case (which)
            TRIG_ROW: row_trig <= 1'b1;
            TRIG_FRAME: frame_trig <= 1'b1;
            default: snap_trig <= 1'b1;
        endcase
        repeat (2) @(posedge mclk);
        row_trig <= 1'b0;
        frame_trig <= 1'b0;
        snap_trig <= 1'b0;
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the video port timing block
`timescale 1ns/1ps
module testbench;
    import video_port_pkg::*;
    localparam int RP = 16;
    logic clk_sys, rst_n, mclk, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, line_sync, frame_sync, pix_valid, ext_sync;
    logic [11:0] pix_data;
    wire row_trig, frame_trig, snap_trig;
    wire [3:0] mon = {ext_sync, pix_valid, frame_sync, line_sync};
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    logic [7:0] offs [5] = '{OFF_CTRL, OFF_LEAD, OFF_ROWDLY, OFF_FRMDLY, OFF_FPC};
    logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'h0, 32'h0, {16'h0, FPC_RST}};

    video_port #(.PIX_W(12), .ROW_PIXELS(RP)) uut (.CLK_SYS(clk_sys), .RESETN(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MCLK(mclk), .ROW_TRIG(row_trig), .FRAME_TRIG(frame_trig),
        .SNAP_TRIG(snap_trig), .LINE_SYNC(line_sync), .FRAME_SYNC(frame_sync), .PIX_VALID(pix_valid),
        .PIX_DATA(pix_data), .EXT_SHUTTER_SYNC(ext_sync));
    trig_model tm (.mclk(mclk), .row_trig(row_trig), .frame_trig(frame_trig), .snap_trig(snap_trig));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // odd offset keeps the link clock out of phase with the system clock
    initial begin
        mclk = 1'b0;
        #7;
        forever #15 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_range(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    // counts link clock edges until the watched output leaves lvl
    task automatic seg(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        while (mon[sel] === lvl && cnt < 20000) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
        if (cnt >= 20000) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    task automatic cfg(input mode_t md, input logic [7:0] ld, input logic [7:0] rdl, input logic [7:0] fdl,
        input logic [15:0] fpc);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_LEAD, {24'h0, ld});
        apb(1'b1, OFF_ROWDLY, {24'h0, rdl});
        apb(1'b1, OFF_FRMDLY, {24'h0, fdl});
        apb(1'b1, OFF_FPC, {16'h0, fpc});
        apb(1'b1, OFF_CTRL, {29'h0, md, 1'b1});
        repeat (20) @(posedge mclk);
        #1;
    endtask

    // first segments after a config change are skipped, then one full period is measured
    task automatic master(input mode_t md, input logic [7:0] ld, input logic [7:0] rdl, input logic [7:0] fdl,
        input int llo, input int lhi, input int flo, input int fhi);
        cfg(md, ld, rdl, fdl, 16'h00c8);
        seg(0, 1'b0, n);
        seg(0, 1'b1, n);
        seg(0, 1'b0, n);
        check_range("line low", llo, llo, n);
        seg(0, 1'b1, n);
        check_range("line high", lhi, lhi, n);
        seg(0, 1'b0, n);
        seg(2, 1'b0, n);
        check_range("lead", int'(ld), int'(ld), n);
        check_val("first pixel", 32'h0, {20'h0, pix_data});
        @(posedge mclk);
        #1;
        check_val("second pixel", 32'h1, {20'h0, pix_data});
        seg(1, 1'b0, n);
        seg(1, 1'b1, n);
        seg(1, 1'b0, n);
        check_range("frame low", flo, flo, n);
        seg(1, 1'b1, n);
        check_range("frame high", fhi, fhi, n);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, offs[i], 32'h0);
            check_val("reset value", rst_val[i], rd);
        end
        apb(1'b1, OFF_LEAD, 32'h000000a5);
        apb(1'b0, OFF_LEAD, 32'h0);
        check_val("lead readback", 32'h000000a5, rd);
        apb(1'b1, 8'h18, 32'h1);
        check_val("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 8'h18, 32'h0);
        check_val("unmapped read err", 32'h1, {31'h0, err});
        check_val("unmapped read data", 32'h0, rd);
        master(MODE_LEVEL, 8'h02, 8'h03, 8'h01, 117, 662, 117, 83);
        master(MODE_PULSE, 8'h05, 8'h00, 8'h00, 16, 764, 16, 16);
        cfg(MODE_SLAVE, 8'h00, 8'h00, 8'h00, 16'h00c8);
        fork
            tm.pulse(TRIG_FRAME);
            begin
                @(posedge mclk);
                #1;
                seg(1, 1'b0, n);
            end
        join
        check_range("frame follow", 2, 3, n);
        for (int r = 0; r < 2; r++) begin
            fork
                tm.pulse(TRIG_ROW);
                begin
                    @(posedge mclk);
                    #1;
                    seg(0, 1'b0, n);
                    check_range("row first pixel", 125, 125, n);
                    check_val("row valid", 32'h1, {31'h0, pix_valid});
                    check_val("row pixel 0", 32'h0, {20'h0, pix_data});
                    seg(2, 1'b1, n);
                    check_range("row length", RP, RP, n);
                end
                begin
                    repeat (60) @(posedge mclk);
                    tm.pulse(TRIG_FRAME);
                end
            join
            repeat (800) @(posedge mclk);
        end
        cfg(MODE_SNAP, 8'h00, 8'h00, 8'h00, 16'h0004);
        fork
            tm.pulse(TRIG_SNAP);
            begin
                @(posedge mclk);
                #1;
                seg(3, 1'b0, n);
            end
        join
        check_range("shutter delay", 3120, 3140, n);
        check_val("line idle", 32'h0, {31'h0, line_sync});
        seg(3, 1'b1, n);
        check_range("shutter width", 1, 1, n);
        repeat (20) @(posedge mclk);
        apb(1'b1, OFF_STATUS, 32'hffffffff);
        apb(1'b0, OFF_STATUS, 32'h0);
        check_val("shots", 32'h1, {16'h0, rd[31:16]});
        end_of_test();
    end
endmodule
